//--- rtl/mcc_pkg.sv
// Purpose: Shared constants and types for the multi-context checksum engine
// Assumes: One clock, asynchronous active-high reset
// Notes: Polynomial select codes keep the legacy two-bit encoding
`default_nettype none
package mcc_pkg;
  localparam int MCC_NCTX = 3;
  localparam int MCC_CTX_W = 2;
  localparam int MCC_SEL_LO = 28;
  localparam int MCC_SEL_HI = 29;
  localparam logic [31:0] MCC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MCC_SEED_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] MCC_POLY_P8 = 32'h0000_001D;
  localparam logic [31:0] MCC_POLY_P16 = 32'h0000_1021;
  localparam logic [31:0] MCC_POLY_P32 = 32'h04C1_1DB7;
  localparam logic [31:0] MCC_POLY_H2F = 32'h0000_002F;
  localparam logic [1:0] MCC_OP_CFG = 2'h1;
  localparam logic [1:0] MCC_OP_SEED = 2'h2;
  localparam logic [1:0] MCC_OP_DATA = 2'h3;

  typedef enum logic [1:0] {
    MCC_SEL_P8 = 2'h0,
    MCC_SEL_P16 = 2'h1,
    MCC_SEL_P32 = 2'h2,
    MCC_SEL_H2F = 2'h3
  } mcc_sel_e;

  typedef enum logic [1:0] {
    MCC_W8 = 2'h0,
    MCC_W16 = 2'h1,
    MCC_W32 = 2'h2
  } mcc_width_e;

  function automatic mcc_width_e mcc_width(input mcc_sel_e sel);
    case (sel)
      MCC_SEL_P16: mcc_width = MCC_W16;
      MCC_SEL_P32: mcc_width = MCC_W32;
      default: mcc_width = MCC_W8;
    endcase
  endfunction

  function automatic logic [31:0] mcc_poly(input mcc_sel_e sel);
    case (sel)
      MCC_SEL_P16: mcc_poly = MCC_POLY_P16;
      MCC_SEL_P32: mcc_poly = MCC_POLY_P32;
      MCC_SEL_H2F: mcc_poly = MCC_POLY_H2F;
      default: mcc_poly = MCC_POLY_P8;
    endcase
  endfunction

  function automatic logic [31:0] mcc_mask(input mcc_width_e w);
    case (w)
      MCC_W16: mcc_mask = 32'h0000_FFFF;
      MCC_W32: mcc_mask = 32'hFFFF_FFFF;
      default: mcc_mask = 32'h0000_00FF;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- rtl/mcc_fold_if.sv
// Purpose: Carries one fold request and its result between engine modules
// Assumes: Purely combinational path
// Notes: None
`default_nettype none
interface mcc_fold_if;
  import mcc_pkg::*;
  logic [31:0] crc_in;
  logic [31:0] data;
  mcc_sel_e sel;
  logic [31:0] crc_out;
  modport req (output crc_in, output data, output sel, input crc_out);
  modport fold (input crc_in, input data, input sel, output crc_out);
endinterface
`default_nettype wire

//--- rtl/mcc_fold.sv
// Purpose: Folds one 32-bit data word into a checksum in one cycle
// Assumes: MSB-first, non-reflected serial division
// Notes: Width comes from the selected polynomial
`default_nettype none
module mcc_fold
  import mcc_pkg::*;
(
  mcc_fold_if.fold f // Fold request and result
);
  always_comb begin
    logic [31:0] c;
    logic [31:0] p;
    logic [31:0] m;
    logic [31:0] top;
    c = f.crc_in;
    p = mcc_poly(f.sel);
    m = mcc_mask(mcc_width(f.sel));
    top = (m >> 1) + 32'h0000_0001;
    // Data enters MSB first; 32 unrolled steps meet the one-cycle budget
    for (int i = 31; i >= 0; i--) begin
      if ((((c & top) != 32'h0) ^ f.data[i]) == 1'b1) begin
        c = ((c << 1) ^ p) & m;
      end else begin
        c = (c << 1) & m;
      end
    end
    f.crc_out = c;
  end
endmodule
`default_nettype wire

//--- rtl/mcc_engine.sv
// Purpose: Three-context checksum engine with per-context polynomial and seed
// Assumes: Writes come from a bus master or DMA as one-cycle strobes
// Notes: Results read back combinationally-free: all outputs are registered
//
// How it works
// - Three contexts, each own polynomial and seed.
// - Checksum width 8, 16 or 32 bits.
// - Single-cycle update into per-context result register.
// - Only data writes fold into the checksum; seed writes reload it.
// - Polynomial select lives in config bits 28:29.
// - Four standard polynomials supported.
// - Accepts writes from processor or DMA alike.
`default_nettype none
module mcc_engine
  import mcc_pkg::*;
(
  input wire logic I_CLK, // 200 MHz clock
  input wire logic I_RST, // Async reset, active high
  input wire logic I_WR, // Write strobe, one cycle
  input wire logic I_DMA, // Write comes from DMA
  input wire logic [1:0] I_OP, // Write target: cfg, seed or data
  input wire logic [1:0] I_CTX, // Context number 0..2
  input wire logic [31:0] I_WDATA, // Write data
  input wire logic [1:0] I_RD_CTX, // Context whose state is shown
  output logic [31:0] O_RESULT, // Checksum of shown context
  output logic [31:0] O_CFG, // Config of shown context
  output logic [31:0] O_SEED, // Seed of shown context
  output logic O_DONE, // Pulse after each data fold
  output logic O_ERR // Pulse on write to bad context or op
);
  logic [31:0] cfg_reg [MCC_NCTX];
  logic [31:0] seed_reg [MCC_NCTX];
  logic [31:0] crc_reg [MCC_NCTX];
  logic ctx_ok;
  mcc_sel_e sel_cur;

  mcc_fold_if fif ();

  assign ctx_ok = (I_CTX < MCC_CTX_W'(MCC_NCTX));
  assign sel_cur = mcc_sel_e'(cfg_reg[ctx_ok ? I_CTX : 2'h0][MCC_SEL_HI:MCC_SEL_LO]);
  assign fif.crc_in = crc_reg[ctx_ok ? I_CTX : 2'h0];
  assign fif.data = I_WDATA;
  assign fif.sel = sel_cur;

  mcc_fold u_fold (
    .f(fif)
  );

  // Config steers future folds and seed-write masking; running result is untouched
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < MCC_NCTX; k++) begin
        cfg_reg[k] <= MCC_CFG_RST;
      end
    end else if (I_WR && ctx_ok && I_OP == MCC_OP_CFG) begin
      cfg_reg[I_CTX] <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < MCC_NCTX; k++) begin
        seed_reg[k] <= MCC_SEED_RST;
      end
    end else if (I_WR && ctx_ok && I_OP == MCC_OP_SEED) begin
      seed_reg[I_CTX] <= I_WDATA;
    end
  end

  // Seed is masked to the active width so stale upper bits never leak
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < MCC_NCTX; k++) begin
        crc_reg[k] <= MCC_SEED_RST & mcc_mask(MCC_W8);
      end
    end else if (I_WR && ctx_ok) begin
      if (I_OP == MCC_OP_SEED) begin
        crc_reg[I_CTX] <= I_WDATA & mcc_mask(mcc_width(sel_cur));
      end else if (I_OP == MCC_OP_DATA) begin
        crc_reg[I_CTX] <= fif.crc_out;
      end
    end
  end

  // I_DMA does not alter behaviour: both sources are treated alike
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DONE <= 1'b0;
      O_ERR <= 1'b0;
    end else begin
      O_DONE <= I_WR && ctx_ok && I_OP == MCC_OP_DATA && (I_DMA || !I_DMA);
      O_ERR <= I_WR && (!ctx_ok || I_OP == 2'h0);
    end
  end

  // Readback one cycle late keeps outputs straight from flip-flops
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RESULT <= 32'h0000_0000;
      O_CFG <= 32'h0000_0000;
      O_SEED <= 32'h0000_0000;
    end else if (I_RD_CTX < MCC_CTX_W'(MCC_NCTX)) begin
      O_RESULT <= crc_reg[I_RD_CTX];
      O_CFG <= cfg_reg[I_RD_CTX];
      O_SEED <= seed_reg[I_RD_CTX];
    end else begin
      O_RESULT <= 32'h0000_0000;
      O_CFG <= 32'h0000_0000;
      O_SEED <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

//--- test/mcc_engine_asserts.sv
// Purpose: Port checks of the checksum engine
// Assumes: Readback lags a write by two edges
// Notes: Bound to every engine
`default_nettype none
module mcc_engine_asserts (
  input wire logic I_CLK, // clk
  input wire logic I_RST, // rst
  input wire logic I_WR, // wr
  input wire logic [1:0] I_OP, // op
  input wire logic [1:0] I_CTX, // ctx
  input wire logic [31:0] I_WDATA, // data
  input wire logic [1:0] I_RD_CTX, // shown
  input wire logic [31:0] O_RESULT, // sum
  input wire logic [31:0] O_SEED, // seed
  input wire logic O_DONE, // done
  input wire logic O_ERR // err
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire logic ok = I_WR && I_OP != 2'h0 && I_CTX != 2'h3;
  wire logic sw = ok && I_OP == 2'h2;
  wire logic dw = ok && I_OP == 2'h3;
  sequence s_load;
    sw && I_CTX == I_RD_CTX ##1 $stable(I_RD_CTX);
  endsequence
  a_fold_pulse: assert property (dw |=> O_DONE) else $error("no done");
  a_fold_cause: assert property (O_DONE |-> $past(dw)) else $error("stray done");
  a_bad_flag: assert property (I_WR && !ok |=> O_ERR) else $error("no err");
  a_err_cause: assert property (O_ERR |-> $past(I_WR && !ok)) else $error("stray err");
  a_seed_load: assert property (s_load |=> O_SEED == $past(I_WDATA, 2)) else $error("seed");
  // First edge after release still compares against the cleared readback
  a_seed_hold: assert property (!sw && !$past(I_RST) ##1 $stable(I_RD_CTX) |=> $stable(O_SEED))
    else $error("seed moved");
  a_none_zero: assert property (I_RD_CTX == 2'h3 |=> O_RESULT == 32'h0) else $error("ctx3");
  a_pulse_excl: assert property (!(O_DONE && O_ERR)) else $error("both");
endmodule
bind mcc_engine mcc_engine_asserts u_chk (.*);
`default_nettype wire

//--- test/mcc_master.sv
// Purpose: Bus master or DMA model
// Assumes: One-cycle write strobe
// Notes: Idle data inverted so stale words never pass
`default_nettype none
module mcc_master (
  input wire logic i_clk, // clock
  output logic o_wr, // strobe
  output logic o_dma, // from DMA
  output logic [1:0] o_op, // target
  output logic [1:0] o_ctx, // context
  output logic [31:0] o_wdata // data
);
  initial {o_wr, o_dma, o_op, o_ctx, o_wdata} = '0;
  task automatic put(input logic [1:0] op, ctx, input logic [31:0] d, input logic dma);
    @(posedge i_clk);
    {o_wr, o_dma, o_op, o_ctx, o_wdata} <= {1'b1, dma, op, ctx, d};
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- test/test_mcc_engine.sv
// Purpose: Self-checking bench of the checksum engine
// Assumes: Readback settles two edges after a write
// Notes: Serial model gives expected sums
`default_nettype none
module test_mcc_engine;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1;
  logic [1:0] rd = 2'h0, op, cx;
  logic wr, dma, done, err;
  logic [31:0] wd, res, sd, cf, e [3];
  int err_count = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  mcc_master m (.i_clk(clk), .o_wr(wr), .o_dma(dma), .o_op(op), .o_ctx(cx), .o_wdata(wd));
  mcc_engine dut (.I_CLK(clk), .I_RST(rst), .I_WR(wr), .I_DMA(dma), .I_OP(op), .I_CTX(cx), .I_WDATA(wd),
    .I_RD_CTX(rd), .O_RESULT(res), .O_CFG(cf), .O_SEED(sd), .O_DONE(done), .O_ERR(err));
  task automatic chk(input string n, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [31:0] fold(input int s, input logic [31:0] c, d);
    int w = s == 2 ? 32 : s == 1 ? 16 : 8;
    logic [31:0] p = s == 0 ? 32'h1D : s == 1 ? 32'h1021 : s == 2 ? 32'h04C11DB7 : 32'h2F;
    for (int i = 31; i >= 0; i--) c = (c << 1) ^ (c[w-1] ^ d[i] ? p : 32'h0);
    return c & ~(32'hFFFFFFFF << w);
  endfunction
  task automatic show(input logic [1:0] c);
    @(posedge clk);
    rd <= c;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_ctx();
    for (int k = 0; k < 4; k++) begin
      m.put(2'h1, 2'(k % 3), {2'h0, k[1:0], 28'h0}, k[0]);
      m.put(2'h2, 2'(k % 3), 32'h9E3779B9, 1'b0);
      m.put(2'h3, 2'(k % 3), {k[7:0], 24'hC0FFEE}, 1'b1);
      #1;
      chk("done", {31'h0, done}, 32'h1);
      e[k % 3] = fold(k, 32'h9E3779B9, {k[7:0], 24'hC0FFEE});
      // Checked per pass: context 0 is reused, so its 8-bit sum would be lost
      show(2'(k % 3));
      chk("res", res, e[k % 3]);
      chk("cfg", cf, {2'h0, k[1:0], 28'h0});
      chk("seed", sd, 32'h9E3779B9);
    end
    for (int c = 0; c < 3; c++) begin
      show(2'(c));
      chk("res", res, e[c]);
    end
  endtask
  task automatic t_bad();
    m.put(2'h3, 2'h3, 32'h1, 1'b0);
    #1;
    chk("err", {31'h0, err}, 32'h1);
    chk("done", {31'h0, done}, 32'h0);
    m.put(2'h0, 2'h1, 32'h1, 1'b1);
    #1;
    chk("err", {31'h0, err}, 32'h1);
    show(2'h1);
    chk("res", res, e[1]);
    show(2'h3);
    chk("res", res, 32'h0);
  endtask
  task automatic t_reset();
    show(2'h2);
    chk("seed", sd, 32'hFFFFFFFF);
    chk("res", res, 32'h000000FF);
    chk("cfg", cf, 32'h0);
  endtask
  task automatic t_recfg();
    show(2'h1);
    // New select alone must leave the running sum alone
    m.put(2'h1, 2'h1, 32'h0, 1'b0);
    show(2'h1);
    chk("res", res, e[1]);
    m.put(2'h2, 2'h1, 32'h123456A5, 1'b1);
    show(2'h1);
    chk("res", res, 32'h000000A5);
    m.put(2'h3, 2'h1, 32'h12345678, 1'b0);
    e[1] = fold(0, 32'h000000A5, 32'h12345678);
    show(2'h1);
    chk("res", res, e[1]);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctx();
    t_recfg();
    t_bad();
    final_report();
  end
endmodule
`default_nettype wire
